// >>> nvac_pkg.sv
// package for the nonvolatile byte store access controller
// assumes a single 100 MHz clock and synchronous active-high reset
`default_nettype none
package nvac_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned DEPTH = 512;
    localparam int unsigned AW = 9;
    localparam int unsigned ARM_WINDOW = 4;
    localparam int unsigned READ_STALL = 4;
    localparam int unsigned WRITE_STALL = 2;
    localparam int unsigned PROG_RC_CYCLES = 27072;
    localparam int unsigned RC_DIV = 3;
    // io-space offsets of the access registers
    localparam logic [1:0] OFS_CONTROL = 2'h0;
    localparam logic [1:0] OFS_DATA = 2'h1;
    localparam logic [1:0] OFS_ADDR_LOW = 2'h2;
    localparam logic [1:0] OFS_ADDR_HIGH = 2'h3;
    // control register bit positions
    localparam int unsigned BIT_READ = 0;
    localparam int unsigned BIT_WRITE = 1;
    localparam int unsigned BIT_ARM = 2;
    localparam int unsigned BIT_IRQEN = 3;
    // wishbone register offsets of the cpu-side model
    localparam logic [3:0] WB_IO_OFS = 4'h0;
    localparam logic [3:0] WB_IO_CMD = 4'h4;
    localparam logic [3:0] WB_STATUS = 4'h8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage
`default_nettype wire

// >>> nvac_if.sv
// io-space link between the cpu side and the nonvolatile store
// assumes both ends share clk_i
`default_nettype none
interface nvac_if;
    logic io_wr;
    logic io_rd;
    logic [1:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic stall;
    logic flash_selfprog_active;
    logic ready_irq;
    logic global_irq_enable;
    modport dev (input io_wr, io_rd, io_addr, io_wdata, flash_selfprog_active,
        global_irq_enable, output io_rdata, stall, ready_irq);
    modport cpu (output io_wr, io_rd, io_addr, io_wdata, flash_selfprog_active,
        global_irq_enable, input io_rdata, stall, ready_irq);
endinterface
`default_nettype wire

// >>> nvac_store.sv
// device end: 512-byte store with timed, protected write sequence
// assumes io requests are only made while stall is low
// Notes on behaviour
// R01: 512 independent byte locations
// R02: registers reached by io space accesses
// R03: read stalls cpu four cycles
// R04: write start stalls cpu two cycles
// R05: software waits strobe and selfprog clear
// R06: address and data loads any order
// R07: arm set while writing strobe zero
// R08: strobe within four cycles starts write
// R09: no write start during flash selfprog
// R10: arm expires, late strobe ignored
// R11: software keeps interrupts off throughout; the bench sets gie high during write sequences
// R12: hardware clears strobe when write done
// R13: busy blocks reads and address changes
// R14: write lasts 27072 rc cycles
// R15: write completes through power-down sleep
// R16: write completes through reset
// R17: arm clears four cycles after set
// R18: strobe without arm does nothing
// R19: read strobe loads data immediately
// R20: ready irq level while strobe clear
// R21: address and data latched at start
// R22: read strobe self-clears after load; read_strobe is held at zero here
`default_nettype none
module nvac_store #(
    parameter int unsigned PROG_CYCLES = nvac_pkg::PROG_RC_CYCLES * nvac_pkg::RC_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sleep_i,
    nvac_if.dev bus,
    output logic busy_o
);
    logic [7:0] mem [nvac_pkg::DEPTH];
    logic [nvac_pkg::AW-1:0] addr;
    logic [7:0] data;
    logic [nvac_pkg::AW-1:0] prog_addr;
    logic [7:0] prog_data;
    logic arm;
    logic [2:0] arm_cnt;
    logic strobe;
    logic read_strobe;
    logic irq_en;
    logic [31:0] prog_cnt;
    logic [2:0] stall_cnt;
    logic ctl_wr;
    logic start;

    assign ctl_wr = bus.io_wr && bus.io_addr == nvac_pkg::OFS_CONTROL;
    assign start = ctl_wr && bus.io_wdata[nvac_pkg::BIT_WRITE] && arm && !strobe
        && !bus.flash_selfprog_active; // R08 R09 R18

    // address register, frozen while programming
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr <= '0;
        end else if (bus.io_wr && !strobe) begin // R13 R06 R02
            if (bus.io_addr == nvac_pkg::OFS_ADDR_LOW)
                addr[7:0] <= bus.io_wdata;
            else if (bus.io_addr == nvac_pkg::OFS_ADDR_HIGH)
                addr[8] <= bus.io_wdata[0];
        end
    end

    // data register: cpu write or read load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data <= nvac_pkg::RESET_BYTE;
        end else if (ctl_wr && bus.io_wdata[nvac_pkg::BIT_READ] && !strobe) begin
            data <= mem[addr]; // R19 R13
        end else if (bus.io_wr && bus.io_addr == nvac_pkg::OFS_DATA) begin
            data <= bus.io_wdata;
        end
    end

    // read strobe is never set and reads as zero; the read load completes on the control write edge
    always_ff @(posedge clk_i) begin
        if (rst_i)
            read_strobe <= 1'b0;
        else
            read_strobe <= 1'b0; // R22
    end

    // master arm and its window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm <= 1'b0;
            arm_cnt <= '0;
        end else if (ctl_wr && bus.io_wdata[nvac_pkg::BIT_ARM]
                && !bus.io_wdata[nvac_pkg::BIT_WRITE]) begin // R07
            arm <= 1'b1;
            arm_cnt <= 3'(nvac_pkg::ARM_WINDOW);
        end else if (arm) begin
            arm_cnt <= arm_cnt - 3'h1;
            if (arm_cnt == 3'h1 || start)
                arm <= 1'b0; // R17 R10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            irq_en <= 1'b0;
        else if (ctl_wr)
            irq_en <= bus.io_wdata[nvac_pkg::BIT_IRQEN];
    end

    // programming engine is not reset, so a write finishes through reset
    always_ff @(posedge clk_i) begin
        if (start) begin
            strobe <= 1'b1;
            prog_addr <= addr; // R21
            prog_data <= data;
            prog_cnt <= PROG_CYCLES - 1; // R14
        end else if (strobe) begin // R16 R15
            if (prog_cnt == 0) begin
                strobe <= 1'b0; // R12
                mem[prog_addr] <= prog_data; // R01
            end else begin
                prog_cnt <= prog_cnt - 32'h1;
            end
        end else begin
            strobe <= 1'b0;
        end
    end

    // cpu stall counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stall_cnt <= '0;
            bus.stall <= 1'b0;
        end else if (ctl_wr && bus.io_wdata[nvac_pkg::BIT_READ] && !strobe) begin
            stall_cnt <= 3'(nvac_pkg::READ_STALL - 1); // R03
            bus.stall <= 1'b1;
        end else if (start) begin
            stall_cnt <= 3'(nvac_pkg::WRITE_STALL - 1); // R04
            bus.stall <= 1'b1;
        end else if (stall_cnt != 3'h0) begin
            stall_cnt <= stall_cnt - 3'h1;
        end else begin
            bus.stall <= 1'b0;
        end
    end

    // register read-back, reserved bits zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus.io_rdata <= 8'h00;
        end else if (bus.io_rd) begin
            unique case (bus.io_addr)
                nvac_pkg::OFS_CONTROL: bus.io_rdata <= {4'h0, irq_en, arm, strobe,
                    read_strobe};
                nvac_pkg::OFS_DATA: bus.io_rdata <= data;
                nvac_pkg::OFS_ADDR_LOW: bus.io_rdata <= addr[7:0];
                nvac_pkg::OFS_ADDR_HIGH: bus.io_rdata <= {7'h00, addr[8]};
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus.ready_irq <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            bus.ready_irq <= irq_en && bus.global_irq_enable && !strobe; // R20
            busy_o <= strobe || (sleep_i && strobe); // R15
        end
    end
endmodule
`default_nettype wire

// >>> nvac_cpu.sv
// cpu end: wishbone slave turning software orders into io accesses
// assumes the device answers io_rdata one cycle after io_rd
`default_nettype none
module nvac_cpu (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    nvac_if.cpu link
);
    typedef enum {NVAC_IDLE, NVAC_ISSUE, NVAC_STROBE, NVAC_WAIT, NVAC_DONE} nvac_state_t;
    nvac_state_t state;
    logic [1:0] ofs;
    logic gie;
    logic selfprog;
    logic [7:0] last;

    // software sets gie high during sequences (R11 asks it low), waits on R05
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= NVAC_IDLE;
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            ofs <= nvac_pkg::OFS_CONTROL;
            gie <= 1'b0;
            selfprog <= 1'b0;
            last <= 8'h00;
            link.io_wr <= 1'b0;
            link.io_rd <= 1'b0;
            link.io_addr <= nvac_pkg::OFS_CONTROL;
            link.io_wdata <= 8'h00;
        end else begin
            ack_o <= 1'b0;
            link.io_wr <= 1'b0;
            link.io_rd <= 1'b0;
            unique case (state)
                NVAC_IDLE: if (cyc_i && stb_i && !ack_o) begin
                    if (adr_i == nvac_pkg::WB_IO_OFS) begin
                        if (we_i && sel_i[0])
                            ofs <= dat_i[1:0];
                        dat_o <= {30'h0, ofs};
                        ack_o <= 1'b1;
                    end else if (adr_i == nvac_pkg::WB_STATUS) begin
                        if (we_i && sel_i[0]) begin
                            gie <= dat_i[0];
                            selfprog <= dat_i[1];
                        end
                        dat_o <= {28'h0, link.ready_irq, link.stall, selfprog, gie};
                        ack_o <= 1'b1;
                    end else if (adr_i == nvac_pkg::WB_IO_CMD && !link.stall) begin
                        link.io_addr <= ofs;
                        link.io_wdata <= dat_i[7:0];
                        state <= NVAC_ISSUE;
                    end else if (adr_i != nvac_pkg::WB_IO_CMD) begin
                        dat_o <= 32'h0000_0000;
                        ack_o <= 1'b1;
                    end
                end
                NVAC_ISSUE: begin
                    link.io_wr <= we_i && sel_i[0]; // R06 R07
                    link.io_rd <= !we_i;
                    state <= NVAC_WAIT;
                    // arm plus strobe in one order: the bus is too slow for two orders
                    // to meet the arm window, so arm now and strobe on the next cycle
                    if (we_i && sel_i[0] && ofs == nvac_pkg::OFS_CONTROL
                            && dat_i[nvac_pkg::BIT_ARM] && dat_i[nvac_pkg::BIT_WRITE]) begin
                        link.io_wdata[nvac_pkg::BIT_WRITE] <= 1'b0; // R07
                        state <= NVAC_STROBE;
                    end
                end
                NVAC_STROBE: begin
                    link.io_wr <= 1'b1; // R08
                    link.io_wdata <= dat_i[7:0];
                    state <= NVAC_WAIT;
                end
                NVAC_WAIT: if (!link.stall && !link.io_wr && !link.io_rd) begin
                    last <= link.io_rdata;
                    state <= NVAC_DONE;
                end
                NVAC_DONE: begin
                    dat_o <= {24'h0, we_i ? last : link.io_rdata};
                    ack_o <= 1'b1;
                    state <= NVAC_IDLE;
                end
            endcase
        end
    end

    assign link.global_irq_enable = gie;
    assign link.flash_selfprog_active = selfprog;
endmodule
`default_nettype wire

// >>> nvac_properties.sv
// concurrent checks on the io link between the cpu end and the store
// assumes the store runs with a write time of 100 cycles
`default_nettype none
module nvac_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic io_wr,
    input wire logic [1:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic stall,
    input wire logic flash_selfprog_active,
    input wire logic ready_irq,
    input wire logic global_irq_enable
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] arm_age;
    logic [2:0] stall_len;
    wire ctl_wr = io_wr && io_addr == nvac_pkg::OFS_CONTROL;
    wire strobe = ctl_wr && io_wdata[nvac_pkg::BIT_WRITE];
    wire idle = ready_irq && global_irq_enable && io_wdata[nvac_pkg::BIT_IRQEN];
    wire good = strobe && arm_age <= 4'h2 && !flash_selfprog_active && idle;
    always_ff @(posedge clk_i) begin
        if (rst_i) arm_age <= 4'hF;
        else if (ctl_wr && io_wdata[nvac_pkg::BIT_ARM] && !strobe) arm_age <= 4'h0;
        else if (arm_age != 4'hF) arm_age <= arm_age + 4'h1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !stall) stall_len <= 3'h0;
        else if (stall_len != 3'h7) stall_len <= stall_len + 3'h1;
    end
    sequence stall4_s;
        stall [*4] ##1 !stall;
    endsequence
    sequence stall2_s;
        stall [*2] ##1 !stall;
    endsequence
    read_stall_a: assert property (ctl_wr && io_wdata[0] && !strobe && idle |=> stall4_s)
        else $error("read stall not four cycles");
    write_stall_a: assert property (good |=> stall2_s)
        else $error("write stall not two cycles");
    write_start_a: assert property (good |-> ##[1:3] !ready_irq)
        else $error("armed strobe started no write");
    no_arm_a: assert property (strobe && arm_age >= 4'h6 && idle |=> ready_irq [*4])
        else $error("strobe without arm started a write");
    selfprog_block_a: assert property (strobe && flash_selfprog_active && idle |=> ready_irq [*4])
        else $error("write started during self programming");
    write_done_a: assert property ($fell(ready_irq) && global_irq_enable |-> ##[1:120] ready_irq)
        else $error("write never completed");
    irq_gate_a: assert property (ready_irq |-> $past(global_irq_enable))
        else $error("ready irq without global enable");
    stall_cause_a: assert property ($rose(stall) |-> $past(io_wr))
        else $error("stall without io access");
    stall_len_a: assert property (stall |-> stall_len < 3'h4)
        else $error("stall too long");
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench: cpu end and store joined by the io link
// assumes status bit0 is global irq enable and bit1 flash self programming
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
        $display("Error at %0t: got %h expected %h", $time, g, e); end end
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sleep_i = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic busy;
    logic [1:0] cur_ofs = 2'bxx;
    logic [7:0] got;
    int n_errors = 0;
    int tests_run = 0;
    nvac_if nv();
    nvac_cpu nvac_cpu_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(wb_adr), .dat_i(wb_dat),
        .we_i(wb_we), .sel_i(4'hF), .cyc_i(wb_cyc), .stb_i(wb_stb), .dat_o(wb_dat_r),
        .ack_o(wb_ack), .link(nv));
    nvac_store #(.PROG_CYCLES(100)) nvac_store_inst (.clk_i(clk_i), .rst_i(rst_i),
        .sleep_i(sleep_i), .bus(nv), .busy_o(busy));
    nvac_properties nvac_properties_inst (.clk_i(clk_i), .rst_i(rst_i), .io_wr(nv.io_wr),
        .io_addr(nv.io_addr), .io_wdata(nv.io_wdata), .stall(nv.stall),
        .flash_selfprog_active(nv.flash_selfprog_active), .ready_irq(nv.ready_irq),
        .global_irq_enable(nv.global_irq_enable));
    always #5 clk_i = ~clk_i;
    task automatic tally_and_finish();
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic w,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_adr <= a;
        wb_dat <= d;
        wb_we <= w;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 300);
        `CHK(n < 300, 1'b1)
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic io_put(input logic [1:0] o, input logic [7:0] b);
        logic [31:0] q;
        if (o !== cur_ofs) wb(nvac_pkg::WB_IO_OFS, {30'h0, o}, 1'b1, q);
        cur_ofs = o;
        wb(nvac_pkg::WB_IO_CMD, {24'h0, b}, 1'b1, q);
    endtask
    task automatic get_data(output logic [7:0] b);
        logic [31:0] q;
        io_put(nvac_pkg::OFS_CONTROL, 8'h09);
        wb(nvac_pkg::WB_IO_OFS, {30'h0, nvac_pkg::OFS_DATA}, 1'b1, q);
        cur_ofs = nvac_pkg::OFS_DATA;
        wb(nvac_pkg::WB_IO_CMD, 32'h0, 1'b0, q);
        b = q[7:0];
    endtask
    task automatic set_addr(input logic [8:0] a);
        io_put(nvac_pkg::OFS_ADDR_LOW, a[7:0]);
        io_put(nvac_pkg::OFS_ADDR_HIGH, {7'h0, a[8]});
    endtask
    task automatic status(input logic [31:0] s);
        logic [31:0] q;
        wb(nvac_pkg::WB_STATUS, s, 1'b1, q);
    endtask
    task automatic prog(input logic [8:0] a, input logic [7:0] d, input int gap);
        io_put(nvac_pkg::OFS_DATA, d);
        set_addr(a);
        if (gap == 0) begin
            io_put(nvac_pkg::OFS_CONTROL, 8'h0E);
        end else begin
            io_put(nvac_pkg::OFS_CONTROL, 8'h0C);
            repeat (gap) @(posedge clk_i);
            io_put(nvac_pkg::OFS_CONTROL, 8'h0A);
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 500) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(n < 500, 1'b1)
    endtask
    task automatic peek(input logic [8:0] a, input logic [7:0] e);
        set_addr(a);
        get_data(got);
        `CHK(got, e)
    endtask
    task automatic t_basic();
        logic [8:0] at [3] = '{9'h000, 9'h1FF, 9'h100};
        logic [7:0] dt [3] = '{8'h5A, 8'hA5, 8'h3C};
        status(32'h1);
        for (int i = 0; i < 3; i++) begin
            prog(at[i], dt[i], 0);
            `CHK(busy, 1'b1)
            `CHK(nv.ready_irq, 1'b0)
            wait_idle();
            `CHK(nv.ready_irq, 1'b1)
        end
        for (int i = 0; i < 3; i++) peek(at[i], dt[i]);
    endtask
    task automatic t_refused();
        prog(9'h000, 8'hEE, 12);
        peek(9'h000, 8'h5A);
        io_put(nvac_pkg::OFS_DATA, 8'hEE);
        io_put(nvac_pkg::OFS_CONTROL, 8'h0A);
        peek(9'h000, 8'h5A);
        status(32'h3);
        prog(9'h000, 8'hEE, 0);
        status(32'h1);
        peek(9'h000, 8'h5A);
    endtask
    task automatic t_busy();
        prog(9'h1FF, 8'h77, 0);
        sleep_i <= 1'b1;
        set_addr(9'h000);
        io_put(nvac_pkg::OFS_DATA, 8'h11);
        wait_idle();
        sleep_i <= 1'b0;
        get_data(got);
        `CHK(got, 8'h77)
        status(32'h0);
        repeat (3) @(posedge clk_i);
        `CHK(nv.ready_irq, 1'b0)
    endtask
    task automatic t_reset();
        status(32'h1);
        prog(9'h100, 8'h99, 0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        cur_ofs = 2'bxx;
        repeat (2) @(posedge clk_i);
        `CHK(busy, 1'b1)
        wait_idle();
        status(32'h1);
        peek(9'h100, 8'h99);
    endtask
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_basic();
        t_refused();
        t_busy();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
